// ---- bench/ecl_mem_model.sv ----
// behavioural model of the serial configuration memory streaming load words
`timescale 1ns/100ps
`default_nettype none
module ecl_mem_model
    import ecl_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // sequence control from the bench
    input  wire logic                  start,
    input  wire logic                  slow,
    input  wire logic [9:0][LD_DW-1:0] words,
    // load word stream towards the loader
    output logic                       ld_valid,
    output logic [LD_AW-1:0]           ld_addr,
    output logic [LD_DW-1:0]           ld_data,
    output logic                       ld_done,
    output logic                       busy
);
    logic [3:0] idx_r;  // next word to send
    logic       gap_r;  // idle cycle between words in slow mode

    // address of each stored word; the last one is unmapped on purpose
    function automatic logic [LD_AW-1:0] word_addr(input logic [3:0] i);
        if (i < 4) return LW_SLOT_P0 + {3'h0, i, 1'b0};
        if (i < 8) return LW_PWR_P0 + {3'h0, i - 4'h4, 1'b0};
        if (i == 8) return LW_PM_P0;
        return 8'h68;
    endfunction : word_addr

    // sends ten words then a done pulse; idle lines toggle so stale data never looks valid
    always_ff @(posedge clk) begin
        ld_valid <= 1'b0;
        ld_done  <= 1'b0;
        ld_addr  <= ~ld_addr;
        ld_data  <= ~ld_data;
        if (rst) begin
            busy    <= 1'b0;
            idx_r   <= 4'h0;
            gap_r   <= 1'b0;
            ld_addr <= 8'h00;
            ld_data <= 16'h0000;
        end else if (!busy) begin
            busy  <= start;
            idx_r <= 4'h0;
        end else if (gap_r) begin
            gap_r <= 1'b0;
        end else if (idx_r == 4'hA) begin
            ld_done <= 1'b1;
            busy    <= 1'b0;
        end else begin
            ld_valid <= 1'b1;
            ld_addr  <= word_addr(idx_r);
            ld_data  <= words[idx_r];
            idx_r    <= idx_r + 4'h1;
            gap_r    <= slow;
        end
    end
endmodule : ecl_mem_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench of the configuration word loader
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ecl_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0, slow = 1'b0;
    logic [9:0][LD_DW-1:0] words = '0, exp_w = '0;
    logic ld_valid, ld_done, busy, load_done, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [LD_AW-1:0] ld_addr;
    logic [LD_DW-1:0] ld_data;
    logic [AV_AW-1:0] avs_address = 8'h00;
    logic [AV_DW-1:0] avs_writedata = 32'h0, avs_readdata, q;
    ecl_slot_cfg_s slot_cfg [NPORT];
    ecl_pwr_cfg_s pwr_cfg [NPORT];
    ecl_pm0_cfg_s pm0_cfg;
    logic [31:0] seed = 32'h896C82C1;
    int err_count = 0, tests_run = 0;

    // clock of 20 ns period
    always #10 clk = ~clk;

    ecl_mem_model mem (.clk(clk), .rst(rst), .start(start), .slow(slow), .words(words), .ld_valid(ld_valid),
        .ld_addr(ld_addr), .ld_data(ld_data), .ld_done(ld_done), .busy(busy));
    ecl_loader dut (.clk(clk), .rst(rst), .ce(ce), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data),
        .ld_done(ld_done), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .slot_cfg(slot_cfg), .pwr_cfg(pwr_cfg), .pm0_cfg(pm0_cfg),
        .load_done(load_done));

    // random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // expected field structs from a load word
    function automatic ecl_slot_cfg_s exp_slot(input logic [15:0] w);
        return {w[15:9], w[6:4], w[3], w[2], w[1], w[0]};
    endfunction : exp_slot
    function automatic ecl_pwr_cfg_s exp_pwr(input logic [15:0] w);
        return {w[15], w[11:10], w[9:8], w[7:0]};
    endfunction : exp_pwr
    function automatic ecl_pm0_cfg_s exp_pm0(input logic [15:0] w);
        return {w[15:8], w[7], w[6], w[5:0]};
    endfunction : exp_pm0

    // counted comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // final verdict
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // one avalon transfer, held until waitrequest is sampled low at a rising edge
    task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            report_and_stop();
        end
        // one idle edge so the next request never reuses this time step
        @(posedge clk);
    endtask : bus_op

    // lets the memory stream its words, bounded wait for the end
    task automatic run_load(input logic s);
        int n;
        n = 0;
        slow  <= s;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            err_count++;
            report_and_stop();
        end
        repeat (2) @(posedge clk);
    endtask : run_load

    // compares every loaded output and register image with exp_w
    task automatic check_all(input logic done, input logic [15:0] cnt);
        for (int p = 0; p < 4; p++) begin
            chk(32'(slot_cfg[p]), 32'(exp_slot(exp_w[p])));
            chk(32'(pwr_cfg[p]), 32'(exp_pwr(exp_w[p + 4])));
            bus_op(1'b0, REG_SLOT0 + 8'(4 * p), 32'h0, q);
            chk(q, {16'h0, exp_w[p] & 16'hFE7F});
            bus_op(1'b0, REG_PWR0 + 8'(4 * p), 32'h0, q);
            chk(q, {16'h0, exp_w[p + 4] & 16'h8FFF});
        end
        chk(32'(pm0_cfg), 32'(exp_pm0(exp_w[8])));
        bus_op(1'b0, REG_PM0, 32'h0, q);
        chk(q, {16'h0, exp_w[8]});
        chk({31'h0, load_done}, {31'h0, done});
        bus_op(1'b0, REG_STAT, 32'h0, q);
        chk(q, {15'h0, done, cnt});
    endtask : check_all

    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_all(1'b0, 16'h0);
        bus_op(1'b0, REG_CTRL, 32'h0, q);
        chk(q, 32'h1);
        $display("test reset done");
        // all ones, all zeros, then random rounds, fast and slow in turn
        for (int r = 0; r < 6; r++) begin
            for (int i = 0; i < 10; i++) begin
                seed = lfsr(lfsr(seed));
                words[i] <= (r == 0) ? 16'hFFFF : (r == 1) ? 16'h0000 : seed[15:0];
            end
            bus_op(1'b1, REG_CTRL, 32'h3, q);
            run_load(r[0]);
            exp_w = words;
            check_all(1'b1, 16'h9);
            $display("test load round %0d done", r);
        end
        // load disabled: words dropped, outputs kept
        bus_op(1'b1, REG_CTRL, 32'h0, q);
        for (int i = 0; i < 10; i++) words[i] <= ~exp_w[i];
        run_load(1'b0);
        check_all(1'b1, 16'h9);
        $display("test load disabled done");
        // clock enable low: loading on, yet words and the done pulse are frozen out
        bus_op(1'b1, REG_CTRL, 32'h1, q);
        ce <= 1'b0;
        run_load(1'b1);
        ce <= 1'b1;
        check_all(1'b1, 16'h9);
        $display("test clock enable low done");
        // clear then unmapped and read-only accesses
        bus_op(1'b1, REG_CTRL, 32'h3, q);
        exp_w = '0;
        check_all(1'b0, 16'h0);
        bus_op(1'b0, 8'hFC, 32'h0, q);
        chk(q, 32'h0);
        bus_op(1'b1, REG_STAT, 32'hFFFF_FFFF, q);
        bus_op(1'b0, REG_STAT, 32'h0, q);
        chk(q, 32'h0);
        $display("test clear and unmapped done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// ---- rtl/ecl_avmm_slave.sv ----
// avalon-mm handshake with one wait state and registered read data
`timescale 1ns/100ps
`default_nettype none
module ecl_avmm_slave
    import ecl_pkg::*;
(
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // bus request side
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    output logic                  avs_waitrequest,
    output logic [AV_DW-1:0]      avs_readdata,
    // register file side
    input  wire logic [AV_DW-1:0] rd_value,
    output logic                  wr_go
);

    ecl_bus_e         st_r;        // handshake state
    logic             req;         // a request is present
    logic [AV_DW-1:0] rdata_r;     // captured read data

    assign req = avs_read | avs_write;

    // wait is released only in the completion cycle while enabled
    assign avs_waitrequest = req & ~(st_r == BS_DONE && ce);
    // write commits at the edge where wait is seen low
    assign wr_go        = avs_write & st_r == BS_DONE & ce;
    assign avs_readdata = rdata_r;

    // one wait state: capture, then complete
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= BS_IDLE;
        end else if (ce) begin
            case (st_r)
                BS_IDLE: st_r <= req ? BS_DONE : BS_IDLE;
                BS_DONE: st_r <= BS_IDLE;
                default: st_r <= BS_IDLE;
            endcase
        end
    end

    // read data sampled in the first cycle, stable through completion
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (ce && st_r == BS_IDLE && avs_read) begin
            rdata_r <= rd_value;
        end
    end

endmodule : ecl_avmm_slave
`default_nettype wire

// ---- rtl/ecl_loader.sv ----
// configuration word loader: maps memory load words into per-port configuration bits
`timescale 1ns/100ps
`default_nettype none
module ecl_loader
    import ecl_pkg::*;
(
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // load words from the memory reader
    input  wire logic             ld_valid,
    input  wire logic [LD_AW-1:0] ld_addr,
    input  wire logic [LD_DW-1:0] ld_data,
    input  wire logic             ld_done,
    // avalon-mm register bus
    input  wire logic [AV_AW-1:0] avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [AV_DW-1:0] avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [AV_DW-1:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // loaded configuration bits
    output ecl_slot_cfg_s         slot_cfg [NPORT],
    output ecl_pwr_cfg_s          pwr_cfg  [NPORT],
    output ecl_pm0_cfg_s          pm0_cfg,
    output logic                  load_done
);

    ecl_hit_s         hit;              // decoded load address
    logic             load_en_r;        // software enable of word acceptance
    logic             done_r;           // sticky end-of-load flag
    logic [15:0]      word_cnt_r;       // count of accepted mapped words
    logic             wr_go;            // write commits this edge
    logic [AV_DW-1:0] rd_value;         // read mux output
    logic             wr_ctrl;          // write to control register
    logic             clr;              // clear request from software
    logic             acc;              // a load word is taken this edge
    ecl_slot_cfg_s    slot_r [NPORT];   // slot bits per port
    ecl_pwr_cfg_s     pwr_r  [NPORT];   // power budget bits per port
    ecl_pm0_cfg_s     pm0_r;            // port 0 pm bits

    // map slot word fields to their configuration bits
    function automatic ecl_slot_cfg_s slot_map(input logic [LD_DW-1:0] w);
        ecl_slot_cfg_s s;
        s.slot_impl                  = w[SW_SLOT];
        s.conn_clock                 = w[SW_CLK];
        s.dsi_required               = w[SW_DSI];
        s.low_priority_channel_count = w[SW_LOW_PRIORITY_CHANNEL_COUNT];
        s.port_num                   = w[SW_PN_MSB:SW_PN_LSB];
        s.tc_vc0_map                 = w[SW_TC_MSB:SW_TC_LSB];
        return s;
    endfunction : slot_map

    // map power budget word fields
    function automatic ecl_pwr_cfg_s pwr_map(input logic [LD_DW-1:0] w);
        ecl_pwr_cfg_s s;
        s.base_power = w[PW_BP_MSB:PW_BP_LSB];
        s.data_scale = w[PW_DS_MSB:PW_DS_LSB];
        s.pm_state   = w[PW_PM_MSB:PW_PM_LSB];
        s.sys_alloc  = w[PW_SYS];
        return s;
    endfunction : pwr_map

    // address classifier of load words
    ecl_word_decode u_dec (
        .ld_addr (ld_addr),
        .hit     (hit)
    );

    // bus handshake
    ecl_avmm_slave u_bus (
        .clk             (clk),
        .rst             (rst),
        .ce              (ce),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_waitrequest (avs_waitrequest),
        .avs_readdata    (avs_readdata),
        .rd_value        (rd_value),
        .wr_go           (wr_go)
    );

    // control write decode, only the low byte lane carries control bits
    assign wr_ctrl = wr_go && avs_address == REG_CTRL && avs_byteenable[0];
    assign clr     = wr_ctrl && avs_writedata[CTRL_CLEAR];
    // words are taken only while enabled and not being cleared
    assign acc     = ce && ld_valid && load_en_r && !clr;

    // load enable bit
    always_ff @(posedge clk) begin
        if (rst) begin
            load_en_r <= CTRL_LOAD_RST;
        end else if (ce && wr_ctrl) begin
            load_en_r <= avs_writedata[CTRL_LOAD_EN];
        end
    end

    // done flag: the end-of-load event wins over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (ce) begin
            if (ld_done) begin
                done_r <= 1'b1;
            end else if (clr) begin
                done_r <= 1'b0;
            end
        end
    end

    // accepted word counter, counts mapped words only
    always_ff @(posedge clk) begin
        if (rst) begin
            word_cnt_r <= '0;
        end else if (ce) begin
            if (clr) begin
                word_cnt_r <= '0;
            end else if (acc && hit.kind != K_NONE) begin
                word_cnt_r <= word_cnt_r + 16'h0001;
            end
        end
    end

    // per-port slot and power budget registers
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        // slot words 60h..66h, one per port
        always_ff @(posedge clk) begin
            if (rst) begin
                slot_r[p] <= '0;
            end else if (ce) begin
                if (clr) begin
                    slot_r[p] <= '0;
                end else if (acc && hit.kind == K_SLOT && hit.port == 2'(p)) begin
                    slot_r[p] <= slot_map(ld_data);
                end
            end
        end
        // power budget words 70h..76h, one per port
        always_ff @(posedge clk) begin
            if (rst) begin
                pwr_r[p] <= '0;
            end else if (ce) begin
                if (clr) begin
                    pwr_r[p] <= '0;
                end else if (acc && hit.kind == K_PWR && hit.port == 2'(p)) begin
                    pwr_r[p] <= pwr_map(ld_data);
                end
            end
        end
        assign slot_cfg[p] = slot_r[p];
        assign pwr_cfg[p]  = pwr_r[p];
    end

    // port 0 power management word 80h
    always_ff @(posedge clk) begin
        if (rst) begin
            pm0_r <= '0;
        end else if (ce) begin
            if (clr) begin
                pm0_r <= '0;
            end else if (acc && hit.kind == K_PM0) begin
                pm0_r.pm_ctrl                 <= ld_data[MW_CTL_MSB:MW_CTL_LSB];
                pm0_r.rx_pol_disable          <= ld_data[MW_RXPOL];
                pm0_r.vga_decode_en           <= ld_data[MW_VGA];
                pm0_r.phy_vendor_control_five <= ld_data[MW_PHY_MSB:MW_PHY_LSB];
            end
        end
    end

    assign pm0_cfg   = pm0_r;
    assign load_done = done_r;

    // register read mux, unmapped addresses read zero
    always_comb begin
        rd_value = '0;
        if (avs_address == REG_CTRL) begin
            rd_value[CTRL_LOAD_EN] = load_en_r;
        end else if (avs_address == REG_STAT) begin
            rd_value = {15'h0000, done_r, word_cnt_r};
        end else if (avs_address == REG_PM0) begin
            rd_value = {16'h0000, pm0_r};
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (avs_address == REG_SLOT0 + AV_AW'(i) * REG_STEP) begin
                    rd_value = {16'h0000, slot_r[i].tc_vc0_map, 2'h0, slot_r[i].port_num,
                                slot_r[i].low_priority_channel_count, slot_r[i].dsi_required,
                                slot_r[i].conn_clock, slot_r[i].slot_impl};
                end else if (avs_address == REG_PWR0 + AV_AW'(i) * REG_STEP) begin
                    rd_value = {16'h0000, pwr_r[i].sys_alloc, 3'h0, pwr_r[i].pm_state,
                                pwr_r[i].data_scale, pwr_r[i].base_power};
                end
            end
        end
    end

    // checking helpers: what was taken at the previous edge
    logic             slot_q;   // slot word taken
    logic             pwr_q;    // power word taken
    logic             pm0_q;    // port 0 pm word taken
    logic [1:0]       port_q;   // its port
    logic [LD_DW-1:0] data_q;   // its data

    // capture the accepted word for the checks
    always_ff @(posedge clk) begin
        slot_q <= acc && hit.kind == K_SLOT;
        pwr_q  <= acc && hit.kind == K_PWR;
        pm0_q  <= acc && hit.kind == K_PM0;
        port_q <= hit.port;
        data_q <= ld_data;
    end

    // all checks run on the one clock and rest while reset is high
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // field checks look one edge after a word was taken, or dropped while loading is off
    no_load_off_a: assert property (ce && ld_valid && !load_en_r && !clr |=> $stable(pm0_r))
        else $error("word loaded while loading is disabled");
    slot_p2_a: assert property (!$past(rst) && slot_q && port_q == PORT2 |-> slot_r[2].slot_impl == data_q[SW_SLOT])
        else $error("port 2 slot implemented bit wrong");
    slot_p3_a: assert property (!$past(rst) && slot_q && port_q == PORT3 |-> slot_r[3].slot_impl == data_q[SW_SLOT])
        else $error("port 3 slot implemented bit wrong");
    conn_clock_a: assert property (!$past(rst) && slot_q |-> slot_r[port_q].conn_clock == data_q[SW_CLK])
        else $error("connector clock bit wrong");
    dsi_bit_a: assert property (!$past(rst) && slot_q |-> slot_r[port_q].dsi_required == data_q[SW_DSI])
        else $error("device init bit wrong");
    lp_channel_a: assert property (!$past(rst) && slot_q
        |-> slot_r[port_q].low_priority_channel_count == data_q[SW_LOW_PRIORITY_CHANNEL_COUNT])
        else $error("low priority channel bit wrong");
    port_number_a: assert property (!$past(rst) && slot_q
        |-> slot_r[port_q].port_num == data_q[SW_PN_MSB:SW_PN_LSB])
        else $error("port number wrong");
    tc_map_a: assert property (!$past(rst) && slot_q
        |-> slot_r[port_q].tc_vc0_map == data_q[SW_TC_MSB:SW_TC_LSB])
        else $error("traffic class map wrong");
    base_power_a: assert property (!$past(rst) && pwr_q
        |-> pwr_r[port_q].base_power == data_q[PW_BP_MSB:PW_BP_LSB])
        else $error("base power wrong");
    data_scale_a: assert property (!$past(rst) && pwr_q
        |-> pwr_r[port_q].data_scale == data_q[PW_DS_MSB:PW_DS_LSB])
        else $error("data scale wrong");
    pm_state_a: assert property (!$past(rst) && pwr_q
        |-> pwr_r[port_q].pm_state == data_q[PW_PM_MSB:PW_PM_LSB])
        else $error("pm state wrong");
    sys_alloc_a: assert property (!$past(rst) && pwr_q |-> pwr_r[port_q].sys_alloc == data_q[PW_SYS])
        else $error("system allocated flag wrong");
    pm_ctrl_a: assert property (!$past(rst) && pm0_q |-> pm0_r.pm_ctrl == data_q[MW_CTL_MSB:MW_CTL_LSB])
        else $error("pm control field wrong");
    rx_pol_a: assert property (!$past(rst) && pm0_q |-> pm0_r.rx_pol_disable == data_q[MW_RXPOL])
        else $error("rx polarity bit wrong");
    vga_decode_a: assert property (!$past(rst) && pm0_q |-> pm0_r.vga_decode_en == data_q[MW_VGA])
        else $error("vga decode bit wrong");
    phy_byte_a: assert property (!$past(rst) && pm0_q
        |-> pm0_r.phy_vendor_control_five == data_q[MW_PHY_MSB:MW_PHY_LSB])
        else $error("phy control byte wrong");
    slot_p0_a: assert property (acc && ld_addr == LW_SLOT_P0 |=> slot_r[0] == slot_map(data_q))
        else $error("port 0 slot word not applied");
    // bookkeeping checks: counter, clear and bus wait state
    word_count_a: assert property (acc && hit.kind != K_NONE
        |=> word_cnt_r == $past(word_cnt_r) + 16'h0001)
        else $error("mapped word not counted");
    unmapped_skip_a: assert property (acc && hit.kind == K_NONE |=> $stable(word_cnt_r))
        else $error("unmapped word counted");
    clear_zero_a: assert property (ce && clr
        |=> word_cnt_r == '0 && pm0_r == '0 && slot_r[2] == '0 && pwr_r[3] == '0)
        else $error("clear left loaded bits");
    // the done flag: a set beats a clear in the same cycle
    done_set_a: assert property (ce && ld_done |=> done_r)
        else $error("done flag not set");
    done_keep_a: assert property (done_r && !(ce && clr) |=> done_r)
        else $error("done flag lost");
    bus_wait_a: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest || !ce)
        else $error("more than one wait state");

    // scenarios that the bench must reach
    slot_load_c: cover property (slot_q ##1 pwr_q);
    pm0_load_c: cover property (pm0_q);
    done_clear_c: cover property (done_r ##1 clr);
    bus_read_c: cover property (avs_read && !avs_waitrequest);
    word_drop_c: cover property (ce && ld_valid && !load_en_r);

endmodule : ecl_loader
`default_nettype wire

// ---- rtl/ecl_pkg.sv ----
// shared constants, field layouts and carrier types of the configuration word loader
package ecl_pkg;

    // widths of the load port and the register bus
    localparam int LD_AW = 8;
    localparam int LD_DW = 16;
    localparam int AV_AW = 8;
    localparam int AV_DW = 32;
    localparam int NPORT = 4;

    // load word addresses in the configuration memory
    localparam logic [LD_AW-1:0] LW_SLOT_P0 = 8'h60;
    localparam logic [LD_AW-1:0] LW_SLOT_P3 = 8'h66;
    localparam logic [LD_AW-1:0] LW_PWR_P0  = 8'h70;
    localparam logic [LD_AW-1:0] LW_PWR_P3  = 8'h76;
    localparam logic [LD_AW-1:0] LW_PM_P0   = 8'h80;

    // port numbers used by the decoder and the checks
    localparam logic [1:0] PORT0 = 2'h0;
    localparam logic [1:0] PORT2 = 2'h2;
    localparam logic [1:0] PORT3 = 2'h3;

    // slot word field positions
    localparam int SW_SLOT   = 0;   // to C0h bit 24
    localparam int SW_CLK    = 1;   // to D0h bit 28
    localparam int SW_DSI    = 2;   // to 40h bit 21
    localparam int SW_LOW_PRIORITY_CHANNEL_COUNT   = 3;   // to 144h bit 4
    localparam int SW_PN_LSB = 4;   // to CCh bits 26:24
    localparam int SW_PN_MSB = 6;
    localparam int SW_TC_LSB = 9;   // to 154h bits 7:1
    localparam int SW_TC_MSB = 15;

    // power budget word field positions
    localparam int PW_BP_LSB = 0;   // to 214h bits 7:0
    localparam int PW_BP_MSB = 7;
    localparam int PW_DS_LSB = 8;   // to 214h bits 9:8
    localparam int PW_DS_MSB = 9;
    localparam int PW_PM_LSB = 10;  // to 214h bits 14:13
    localparam int PW_PM_MSB = 11;
    localparam int PW_SYS    = 15;  // to 218h bit 0

    // port 0 power management word field positions
    localparam int MW_CTL_LSB = 0;  // to 74h bits 13:8
    localparam int MW_CTL_MSB = 5;
    localparam int MW_RXPOL   = 6;  // to 74h bit 14
    localparam int MW_VGA     = 7;  // to 70h bit 31
    localparam int MW_PHY_LSB = 8;  // to 88h bits 31:24
    localparam int MW_PHY_MSB = 15;

    // register byte addresses
    localparam logic [AV_AW-1:0] REG_CTRL  = 8'h00;
    localparam logic [AV_AW-1:0] REG_STAT  = 8'h04;
    localparam logic [AV_AW-1:0] REG_SLOT0 = 8'h10;
    localparam logic [AV_AW-1:0] REG_PWR0  = 8'h20;
    localparam logic [AV_AW-1:0] REG_PM0   = 8'h30;
    localparam logic [AV_AW-1:0] REG_STEP  = 8'h04;

    // control and status bit positions, reset values
    localparam int   CTRL_LOAD_EN = 0;
    localparam int   CTRL_CLEAR   = 1;
    localparam int   STAT_DONE    = 16;
    localparam logic CTRL_LOAD_RST = 1'b1;

    // kind of a load word
    typedef enum logic [1:0] {
        K_NONE = 2'b00,
        K_SLOT = 2'b01,
        K_PWR  = 2'b10,
        K_PM0  = 2'b11
    } ecl_kind_e;

    // bus handshake states
    typedef enum logic {
        BS_IDLE = 1'b0,
        BS_DONE = 1'b1
    } ecl_bus_e;

    // decoded load word address
    typedef struct packed {
        ecl_kind_e  kind;
        logic [1:0] port;
    } ecl_hit_s;

    // per-port slot, clock, init, channel, numbering, mapping bits
    typedef struct packed {
        logic [6:0] tc_vc0_map;
        logic [2:0] port_num;
        logic       low_priority_channel_count;
        logic       dsi_required;
        logic       conn_clock;
        logic       slot_impl;
    } ecl_slot_cfg_s;

    // per-port power budget bits
    typedef struct packed {
        logic       sys_alloc;
        logic [1:0] pm_state;
        logic [1:0] data_scale;
        logic [7:0] base_power;
    } ecl_pwr_cfg_s;

    // port 0 power management and phy bits
    typedef struct packed {
        logic [7:0] phy_vendor_control_five;
        logic       vga_decode_en;
        logic       rx_pol_disable;
        logic [5:0] pm_ctrl;
    } ecl_pm0_cfg_s;

endpackage : ecl_pkg

// ---- rtl/ecl_word_decode.sv ----
// decoder from a load word address to its kind and port
`timescale 1ns/100ps
`default_nettype none
module ecl_word_decode
    import ecl_pkg::*;
(
    // load word address
    input  wire logic [LD_AW-1:0] ld_addr,
    // decoded kind and port
    output ecl_hit_s              hit
);

    // classify one address; odd addresses and gaps map to none
    function automatic ecl_hit_s decode(input logic [LD_AW-1:0] a);
        ecl_hit_s         h;
        logic [LD_AW-1:0] d;
        h = '{kind: K_NONE, port: 2'h0};
        d = '0;
        if (a[0] == 1'b0 && a >= LW_SLOT_P0 && a <= LW_SLOT_P3) begin
            d = a - LW_SLOT_P0;
            h = '{kind: K_SLOT, port: d[2:1]};
        end else if (a[0] == 1'b0 && a >= LW_PWR_P0 && a <= LW_PWR_P3) begin
            d = a - LW_PWR_P0;
            h = '{kind: K_PWR, port: d[2:1]};
        end else if (a == LW_PM_P0) begin
            h = '{kind: K_PM0, port: PORT0};
        end
        return h;
    endfunction : decode

    // purely combinational lookup
    assign hit = decode(ld_addr);

endmodule : ecl_word_decode
`default_nettype wire
